// >>> hdl/conv_if.sv
`timescale 1ns/1ns

interface conv_if;
    logic            run;
    logic            halt;
    logic            cont_mode;
    mon_pkg::byte_t  chan_dis;
    logic            shot;
    logic            bus_busy;
    logic            active;
    logic            commit;
    mon_pkg::chan_t  commit_chan;
    mon_pkg::code_t  commit_code;

    modport seq
    (
        input  run,
        input  halt,
        input  cont_mode,
        input  chan_dis,
        input  shot,
        input  bus_busy,
        output active,
        output commit,
        output commit_chan,
        output commit_code
    );

    modport core
    (
        output run,
        output halt,
        output cont_mode,
        output chan_dis,
        output shot,
        output bus_busy,
        input  active,
        input  commit,
        input  commit_chan,
        input  commit_code
    );
endinterface // conv_if

// >>> hdl/conv_sequencer.sv
`timescale 1ns/1ns
`include "mon_regs.svh"

module conv_sequencer #(
    parameter int VOLT_CYC = `VOLT_CONV_CYC,
    parameter int TEMP_CYC = `TEMP_CONV_CYC,
    parameter int LP_CYC   = `LOW_POWER_PASS_CYC
) (
    input  wire logic           clk,
    input  wire logic           rst,
    conv_if.seq                 cif,
    output logic                adc_start,
    output mon_pkg::chan_t      adc_chan,
    input  wire mon_pkg::code_t adc_code
);

    mon_pkg::seq_state_t state_q;
    mon_pkg::seq_state_t state_d;
    mon_pkg::chan_t      chan_q;
    mon_pkg::chan_t      chan_d;
    mon_pkg::code_t      code_q;
    logic [31:0]         timer_q;
    logic [31:0]         period_q;
    logic                shot_q;
    logic                shot_clr;
    logic                launch;
    logic                new_pass;
    logic [3:0]          first_en;
    logic [3:0]          after_en;

    // First enabled channel at or above from; bit 3 set means none left
    function automatic logic [3:0] next_enabled(input logic [7:0] dis, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--)
        begin
            if (!dis[i] && (4'(i) >= from))
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    assign first_en = next_enabled(cif.chan_dis, 4'h0);
    assign after_en = next_enabled(cif.chan_dis, {1'b0, chan_q} + 4'h1);

    // ======================================================================
    // Pass control
    // ======================================================================
    always_comb
    begin
        state_d  = state_q;
        chan_d   = chan_q;
        launch   = 1'b0;
        new_pass = 1'b0;
        shot_clr = 1'b0;
        unique case (state_q)
            mon_pkg::SEQ_IDLE:
            begin
                if (!cif.halt && (cif.run || shot_q))
                begin
                    if (first_en[3])
                    begin
                        shot_clr = 1'b1;
                    end
                    else
                    begin
                        launch   = 1'b1;
                        new_pass = 1'b1;
                        chan_d   = first_en[2:0];
                    end
                end
            end
            mon_pkg::SEQ_CONVERT:
            begin
                if (timer_q == 32'h0)
                begin
                    state_d = mon_pkg::SEQ_HOLD;
                end
            end
            mon_pkg::SEQ_HOLD:
            begin
                // Finished result waits here while the bus is busy
                if (!cif.bus_busy)
                begin
                    if (!cif.halt && (cif.run || shot_q) && !after_en[3])
                    begin
                        launch = 1'b1;
                        chan_d = after_en[2:0];
                    end
                    else if (shot_q)
                    begin
                        shot_clr = 1'b1;
                        state_d  = mon_pkg::SEQ_IDLE;
                    end
                    else if (cif.halt || !cif.run)
                    begin
                        state_d = mon_pkg::SEQ_IDLE;
                    end
                    else if (cif.cont_mode && !first_en[3])
                    begin
                        launch   = 1'b1;
                        new_pass = 1'b1;
                        chan_d   = first_en[2:0];
                    end
                    else
                    begin
                        state_d = mon_pkg::SEQ_REST;
                    end
                end
            end
            mon_pkg::SEQ_REST:
            begin
                if (cif.halt || !cif.run)
                begin
                    state_d = mon_pkg::SEQ_IDLE;
                end
                else if (period_q >= 32'(LP_CYC - 1))
                begin
                    state_d = mon_pkg::SEQ_IDLE;
                end
            end
        endcase
        if (launch)
        begin
            state_d = mon_pkg::SEQ_CONVERT;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= mon_pkg::SEQ_IDLE;
            chan_q  <= '0;
        end
        else
        begin
            state_q <= state_d;
            chan_q  <= chan_d;
        end
    end

    // ======================================================================
    // Single pass request
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shot_q <= 1'b0;
        end
        else if (cif.shot)
        begin
            shot_q <= 1'b1;
        end
        else if (shot_clr)
        begin
            shot_q <= 1'b0;
        end
    end

    // ======================================================================
    // Conversion timer and pass period
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            timer_q <= '0;
        end
        else if (launch)
        begin
            timer_q <= (chan_d == `TEMP_CHAN) ? 32'(TEMP_CYC - 1) : 32'(VOLT_CYC - 1);
        end
        else if (timer_q != 32'h0)
        begin
            timer_q <= timer_q - 32'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            period_q <= '0;
        end
        else if (new_pass)
        begin
            period_q <= '0;
        end
        else if (period_q != 32'hFFFFFFFF)
        begin
            period_q <= period_q + 32'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            code_q    <= '0;
            adc_start <= 1'b0;
            adc_chan  <= '0;
        end
        else
        begin
            adc_start <= launch;
            if (launch)
            begin
                adc_chan <= chan_d;
            end
            if ((state_q == mon_pkg::SEQ_CONVERT) && (timer_q == 32'h0))
            begin
                code_q <= adc_code;
            end
        end
    end

    assign cif.active      = (state_q == mon_pkg::SEQ_CONVERT) || (state_q == mon_pkg::SEQ_HOLD);
    assign cif.commit      = (state_q == mon_pkg::SEQ_HOLD) && !cif.bus_busy;
    assign cif.commit_chan = chan_q;
    assign cif.commit_code = code_q;

endmodule // conv_sequencer

// >>> hdl/mon_pkg.sv
package mon_pkg;

    typedef logic [2:0]  chan_t;
    typedef logic [11:0] code_t;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;

    typedef enum logic [1:0]
    {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_HOLD,
        SEQ_REST
    } seq_state_t;

endpackage

// >>> hdl/mon_regs.svh
`ifndef MON_REGS_SVH
`define MON_REGS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_MHZ             100
`define VOLT_CONV_US        12200
`define TEMP_CONV_US        3600
`define LOW_POWER_PASS_MS   728
`define VOLT_CONV_CYC       (`VOLT_CONV_US * `CLK_MHZ)
`define TEMP_CONV_CYC       (`TEMP_CONV_US * `CLK_MHZ)
`define LOW_POWER_PASS_CYC  (`LOW_POWER_PASS_MS * 1000 * `CLK_MHZ)

// ==========================================================================
// Register offsets
// ==========================================================================
`define OFS_CONFIG          8'h00
`define OFS_ALARM_STATUS    8'h01
`define OFS_ALARM_MASK      8'h03
`define OFS_RATE_SELECT     8'h07
`define OFS_CHAN_DISABLE    8'h08
`define OFS_SINGLE_PASS     8'h09
`define OFS_DEEP_SLEEP      8'h0A
`define OFS_BUSY            8'h0C
`define OFS_RESULT_BASE     8'h20
`define OFS_RESULT_LAST     8'h27
`define OFS_LIMIT_BASE      8'h2A
`define OFS_LIMIT_LAST      8'h39

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define CFG_RUN_BIT         0
`define CFG_ALARM_EN_BIT    1
`define CFG_ALARM_CLR_BIT   3
`define CFG_INIT_BIT        7
`define DEEP_SLEEP_BIT      0
`define RATE_CONT_BIT       0
`define BUSY_BIT            0
`define TEMP_CHAN           3'h7
`define TEMP_HOT_IDX        4'hE
`define TEMP_HYST_IDX       4'hF
`define CONFIG_RST          8'h08
`define ZERO_RST            8'h00

`endif

// >>> hdl/monitor_sequencer_alarm_logic.sv
`timescale 1ns/1ns
`include "mon_regs.svh"

module monitor_sequencer_alarm_logic #(
    parameter int VOLT_CYC = `VOLT_CONV_CYC,
    parameter int TEMP_CYC = `TEMP_CONV_CYC,
    parameter int LP_CYC   = `LOW_POWER_PASS_CYC
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire mon_pkg::byte_t reg_addr,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    input  wire mon_pkg::byte_t reg_wdata,
    output mon_pkg::word_t      reg_rdata,
    output logic                reg_rvalid,
    input  wire logic           bus_busy,
    output logic                adc_start,
    output mon_pkg::chan_t      adc_chan,
    input  wire mon_pkg::code_t adc_code,
    output logic                alarm_o,
    output logic                alarm_oe
);

    conv_if cif ();

    mon_pkg::byte_t config_q;
    mon_pkg::byte_t alarm_status_q;
    mon_pkg::byte_t alarm_mask_q;
    mon_pkg::byte_t conversion_rate_select_q;
    mon_pkg::byte_t chan_disable_q;
    mon_pkg::byte_t deep_sleep_control_q;
    mon_pkg::byte_t limit_q [16];
    mon_pkg::byte_t rd_q;
    logic           res_sel_q;
    logic           alarm_oe_q;
    logic           temp_latch_q;
    logic           temp_below_q;
    logic           init;
    logic           status_rd;
    logic           wr_single_pass;
    mon_pkg::word_t mem_rdata;
    mon_pkg::word_t mem_wdata;
    mon_pkg::byte_t status_set;
    logic [3:0]     lim_idx;
    logic [3:0]     hi_idx;
    logic [3:0]     lo_idx;
    logic           is_temp;
    logic           volt_fault;
    logic           temp_hot;
    logic           temp_low;
    logic signed [9:0] temp_val;
    logic signed [9:0] hot_val;
    logic signed [9:0] hyst_val;

    // ======================================================================
    // Address decoding
    // ======================================================================
    function automatic logic is_limit(input logic [7:0] a);
        return (a >= `OFS_LIMIT_BASE) && (a <= `OFS_LIMIT_LAST);
    endfunction

    function automatic logic is_result(input logic [7:0] a);
        return (a >= `OFS_RESULT_BASE) && (a <= `OFS_RESULT_LAST);
    endfunction

    assign lim_idx        = 4'(reg_addr - `OFS_LIMIT_BASE);
    assign init           = reg_wr && (reg_addr == `OFS_CONFIG) && reg_wdata[`CFG_INIT_BIT];
    assign status_rd      = reg_rd && (reg_addr == `OFS_ALARM_STATUS);
    assign wr_single_pass = reg_wr && (reg_addr == `OFS_SINGLE_PASS);

    // ======================================================================
    // Control registers
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (rst || init)
        begin
            config_q <= `CONFIG_RST;
        end
        else if (reg_wr && (reg_addr == `OFS_CONFIG))
        begin
            // Initialise bit never stored, it self-clears
            config_q <= {1'b0, reg_wdata[6:0]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || init)
        begin
            alarm_mask_q             <= `ZERO_RST;
            conversion_rate_select_q <= `ZERO_RST;
            chan_disable_q           <= `ZERO_RST;
            deep_sleep_control_q     <= `ZERO_RST;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `OFS_ALARM_MASK:   alarm_mask_q             <= reg_wdata;
                `OFS_RATE_SELECT:  conversion_rate_select_q <= reg_wdata;
                `OFS_CHAN_DISABLE: chan_disable_q           <= reg_wdata;
                `OFS_DEEP_SLEEP:   deep_sleep_control_q     <= reg_wdata & 8'h01;
                default:           ;
            endcase
        end
    end

    // Limits survive the initialise bit, like the results
    always_ff @(posedge clk)
    begin
        if (reg_wr && is_limit(reg_addr))
        begin
            limit_q[lim_idx] <= reg_wdata;
        end
    end

    // ======================================================================
    // Sequencer and result store
    // ======================================================================
    assign cif.run       = config_q[`CFG_RUN_BIT];
    assign cif.halt      = config_q[`CFG_ALARM_CLR_BIT];
    assign cif.cont_mode = conversion_rate_select_q[`RATE_CONT_BIT];
    assign cif.chan_dis  = chan_disable_q;
    // Deep shutdown only cuts power elsewhere; a pass from it returns there unchanged
    assign cif.shot      = wr_single_pass && !config_q[`CFG_RUN_BIT];
    assign cif.bus_busy  = bus_busy;

    conv_sequencer #(
        .VOLT_CYC (VOLT_CYC),
        .TEMP_CYC (TEMP_CYC),
        .LP_CYC   (LP_CYC)
    ) u_seq (
        .clk       (clk),
        .rst       (rst),
        .cif       (cif.seq),
        .adc_start (adc_start),
        .adc_chan  (adc_chan),
        .adc_code  (adc_code)
    );

    assign is_temp   = (cif.commit_chan == `TEMP_CHAN);
    assign mem_wdata = is_temp ? {7'h00, cif.commit_code[8:0]} : {4'h0, cif.commit_code};

    result_mem #(
        .DEPTH (8),
        .WIDTH (16)
    ) u_results (
        .clk     (clk),
        .rst     (rst),
        .we      (cif.commit),
        .waddr   (cif.commit_chan),
        .wdata   (mem_wdata),
        .raddr   (reg_addr[2:0]),
        .rdata_q (mem_rdata)
    );

    // ======================================================================
    // Window comparators
    // ======================================================================
    assign hi_idx     = {cif.commit_chan, 1'b0};
    assign lo_idx     = {cif.commit_chan, 1'b1};
    // Eight-bit limits meet the top eight bits of the twelve-bit code
    assign volt_fault = (cif.commit_code[11:4] > limit_q[hi_idx]) ||
                        (cif.commit_code[11:4] <= limit_q[lo_idx]);

    // Both sides in half degrees, sign extended
    assign temp_val   = $signed({cif.commit_code[8], cif.commit_code[8:0]});
    assign hot_val    = $signed({limit_q[`TEMP_HOT_IDX][7], limit_q[`TEMP_HOT_IDX], 1'b0});
    assign hyst_val   = $signed({limit_q[`TEMP_HYST_IDX][7], limit_q[`TEMP_HYST_IDX], 1'b0});
    assign temp_hot   = temp_val > hot_val;
    assign temp_low   = temp_val <= hyst_val;

    always_comb
    begin
        status_set = 8'h00;
        if (cif.commit)
        begin
            if (is_temp)
            begin
                status_set[`TEMP_CHAN] = temp_hot || temp_latch_q;
            end
            else
            begin
                status_set[cif.commit_chan] = volt_fault;
            end
        end
    end

    // ======================================================================
    // Temperature hysteresis
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (rst || init)
        begin
            temp_below_q <= 1'b1;
        end
        else if (cif.commit && is_temp)
        begin
            temp_below_q <= temp_low;
        end
    end

    // Stays armed through reads until a read follows a reading at or below hysteresis
    always_ff @(posedge clk)
    begin
        if (rst || init)
        begin
            temp_latch_q <= 1'b0;
        end
        else if (cif.commit && is_temp && temp_hot)
        begin
            temp_latch_q <= 1'b1;
        end
        else if (status_rd && temp_below_q)
        begin
            temp_latch_q <= 1'b0;
        end
    end

    // ======================================================================
    // Status and alarm
    // ======================================================================
    // A breach landing with the clearing read survives it; alarm clear never touches this
    always_ff @(posedge clk)
    begin
        if (rst || init)
        begin
            alarm_status_q <= `ZERO_RST;
        end
        else
        begin
            alarm_status_q <= (status_rd ? 8'h00 : alarm_status_q) | status_set;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            alarm_oe_q <= 1'b0;
        end
        else
        begin
            alarm_oe_q <= !config_q[`CFG_ALARM_CLR_BIT] && config_q[`CFG_ALARM_EN_BIT] &&
                          (|(alarm_status_q & ~alarm_mask_q));
        end
    end

    // Open drain: only ever pulls low
    assign alarm_o  = 1'b0;
    assign alarm_oe = alarm_oe_q;

    // ======================================================================
    // Read path
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_q       <= '0;
            res_sel_q  <= 1'b0;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                res_sel_q <= is_result(reg_addr);
                rd_q      <= 8'h00;
                if (is_limit(reg_addr))
                begin
                    rd_q <= limit_q[lim_idx];
                end
                else
                begin
                    unique case (reg_addr)
                        `OFS_CONFIG:       rd_q <= config_q;
                        `OFS_ALARM_STATUS: rd_q <= alarm_status_q;
                        `OFS_ALARM_MASK:   rd_q <= alarm_mask_q;
                        `OFS_RATE_SELECT:  rd_q <= conversion_rate_select_q;
                        `OFS_CHAN_DISABLE: rd_q <= chan_disable_q;
                        `OFS_DEEP_SLEEP:   rd_q <= deep_sleep_control_q;
                        `OFS_BUSY:         rd_q <= {7'h00, cif.active};
                        default:           rd_q <= 8'h00;
                    endcase
                end
            end
        end
    end

    assign reg_rdata = res_sel_q ? mem_rdata : {8'h00, rd_q};

endmodule // monitor_sequencer_alarm_logic

// >>> hdl/result_mem.sv
`timescale 1ns/1ns

module result_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_q
);

    // Contents are left unknown after reset, as the results are
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= mem_q[raddr];
        end
    end

endmodule // result_mem

// >>> test/host_model.sv
`timescale 1ns/1ns
module host_model (
    input  wire logic           clk,
    output mon_pkg::byte_t      reg_addr,
    output logic                reg_wr,
    output logic                reg_rd,
    output mon_pkg::byte_t      reg_wdata,
    output logic                bus_busy,
    input  wire mon_pkg::word_t reg_rdata
);
    // ==========
    // One framed transfer, busy held around the strobe
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, bus_busy} = '0;
    end
    task automatic xfer(input mon_pkg::byte_t a, input logic w, input mon_pkg::byte_t d, output mon_pkg::word_t q);
        @(negedge clk);
        bus_busy = 1'b1;
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
        @(negedge clk);
        {reg_wr, reg_rd} = 2'b00;
        q = reg_rdata;
        @(negedge clk);
        bus_busy = 1'b0;
    endtask
endmodule // host_model

// >>> test/mon_asserts.sv
`timescale 1ns/1ns
module mon_asserts #(
    parameter int VOLT_CYC = 20,
    parameter int TEMP_CYC = 8
) (
    input wire logic           clk,
    input wire logic           rst,
    input wire mon_pkg::byte_t reg_addr,
    input wire logic           reg_rd,
    input wire mon_pkg::word_t reg_rdata,
    input wire logic           reg_rvalid,
    input wire logic           bus_busy,
    input wire logic           adc_start,
    input wire mon_pkg::chan_t adc_chan,
    input wire logic           alarm_o,
    input wire logic           alarm_oe
);
    // ==========
    // Spacing of conversions
    int             cnt_q;
    logic           seen_q;
    mon_pkg::chan_t chan_q;
    always_ff @(posedge clk)
    begin
        cnt_q <= (rst || adc_start) ? 1 : cnt_q + 1;
    end
    always_ff @(posedge clk)
    begin
        seen_q <= !rst && (seen_q || adc_start);
    end
    always_ff @(posedge clk)
    begin
        if (adc_start)
        begin
            chan_q <= adc_chan;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Busy on both sides, so no commit can race the clear
    sequence status_read;
        $past(bus_busy) && bus_busy && reg_rd && reg_addr == 8'h01;
    endsequence
    a_rvalid_one_late: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer late");
    a_pass_reads_zero: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata == 16'h0000)
        else $error("trigger read not zero");
    a_volt_result_width: assert property (reg_rd && reg_addr inside {[8'h20:8'h26]} |=> reg_rdata[15:12] == 4'h0)
        else $error("voltage result too wide");
    a_temp_result_width: assert property (reg_rd && reg_addr == 8'h27 |=> reg_rdata[15:9] == 7'h00)
        else $error("temperature result too wide");
    a_alarm_pin_low: assert property (alarm_o == 1'b0)
        else $error("alarm data not low");
    a_read_drops_alarm: assert property (status_read ##1 bus_busy |=> !alarm_oe)
        else $error("alarm stayed after status read");
    a_conv_spacing: assert property (adc_start && seen_q |-> cnt_q >= ((chan_q == 3'h7) ? TEMP_CYC : VOLT_CYC))
        else $error("conversion too short");
    a_chan_ascending: assert property (adc_start && seen_q && chan_q != 3'h7 && cnt_q < VOLT_CYC + 8 |-> adc_chan > chan_q)
        else $error("channel order broken");
endmodule // mon_asserts

// >>> test/monitor_sequencer_alarm_logic_tb_top.sv
`timescale 1ns/1ns
module monitor_sequencer_alarm_logic_tb_top;
    typedef struct packed {mon_pkg::byte_t a; mon_pkg::byte_t d; mon_pkg::word_t e;} row_t;
    logic           clk, rst, reg_wr, reg_rd, reg_rvalid, bus_busy, adc_start, alarm_o, alarm_oe;
    mon_pkg::byte_t reg_addr, reg_wdata;
    mon_pkg::word_t reg_rdata, q;
    mon_pkg::chan_t adc_chan;
    mon_pkg::code_t adc_code;
    int             num_errors = 0, n_tests = 0, cyc = 0, n;
    row_t           rows [11] = '{'{8'h03, 8'hA5, 16'h00A5}, '{8'h03, 8'h00, 16'h0000}, '{8'h07, 8'h01, 16'h0001},
        '{8'h08, 8'h7E, 16'h007E}, '{8'h0A, 8'hFF, 16'h0001}, '{8'h0A, 8'h00, 16'h0000}, '{8'h09, 8'h5A, 16'h0000},
        '{8'h01, 8'hFF, 16'h0000}, '{8'h39, 8'hE7, 16'h00E7}, '{8'h38, 8'h7D, 16'h007D}, '{8'h3E, 8'h12, 16'h0000}};
    monitor_sequencer_alarm_logic #(.VOLT_CYC(20), .TEMP_CYC(8), .LP_CYC(400)) dut_u
    (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bus_busy(bus_busy), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_code(adc_code), .alarm_o(alarm_o), .alarm_oe(alarm_oe)
    );
    host_model h_u
    (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .bus_busy(bus_busy), .reg_rdata(reg_rdata)
    );
    // ==========
    // Helpers
    task automatic chk(input mon_pkg::word_t seen, input mon_pkg::word_t exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input mon_pkg::byte_t a, input mon_pkg::byte_t d);
        h_u.xfer(a, 1'b1, d, q);
    endtask
    task automatic rdc(input mon_pkg::byte_t a, input mon_pkg::word_t e);
        h_u.xfer(a, 1'b0, 8'h00, q);
        chk(q, e);
    endtask
    task automatic count_starts(input int c);
        n = 0;
        repeat (c)
        begin
            @(negedge clk);
            n += int'(adc_start === 1'b1);
        end
    endtask
    // A new pass at channel 0 means the last temperature result is in
    task automatic wait_pass;
        repeat (3) @(negedge clk);
        while (!(adc_start === 1'b1 && adc_chan === 3'h0)) @(negedge clk);
    endtask
    task automatic report_and_stop;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    // ==========
    // Sequence
    initial
    begin
        rst = 1'b1;
        adc_code = 12'hFF0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rdc(8'h00, 16'h0008);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        wr(8'h2A, 8'hF0);
        wr(8'h2B, 8'h00);
        wr(8'h00, 8'h03);
        wait_pass;
        wait_pass;
        chk({15'h0000, alarm_oe}, 16'h0001);
        wr(8'h00, 8'h0B);
        count_starts(40);
        count_starts(100);
        chk(16'(n), 16'h0000);
        chk({15'h0000, alarm_oe}, 16'h0000);
        rdc(8'h01, 16'h0001);
        rdc(8'h20, 16'h0FF0);
        rdc(8'h27, 16'h01F0);
        wr(8'h03, 8'h01);
        wr(8'h00, 8'h03);
        wait_pass;
        wait_pass;
        chk({15'h0000, alarm_oe}, 16'h0000);
        adc_code = 12'h032;
        wr(8'h38, 8'h14);
        wait_pass;
        wr(8'h03, 8'h01);
        h_u.xfer(8'h01, 1'b0, 8'h00, q);
        wait_pass;
        rdc(8'h01, 16'h0080);
        wr(8'h38, 8'h7D);
        wait_pass;
        rdc(8'h01, 16'h0080);
        wr(8'h39, 8'h19);
        wait_pass;
        rdc(8'h01, 16'h0080);
        wait_pass;
        rdc(8'h01, 16'h0000);
        wr(8'h00, 8'h00);
        count_starts(60);
        fork
            wr(8'h09, 8'h00);
            count_starts(100);
        join
        chk(16'(n), 16'h0002);
        wr(8'h0A, 8'h01);
        fork
            wr(8'h09, 8'h00);
            count_starts(100);
        join
        chk(16'(n), 16'h0002);
        wr(8'h0A, 8'h00);
        wr(8'h07, 8'h00);
        wr(8'h00, 8'h01);
        count_starts(380);
        chk(16'(n), 16'h0001);
        report_and_stop();
    end
endmodule // monitor_sequencer_alarm_logic_tb_top
bind monitor_sequencer_alarm_logic mon_asserts #(.VOLT_CYC(VOLT_CYC), .TEMP_CYC(TEMP_CYC)) chk_u
(
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bus_busy(bus_busy), .adc_start(adc_start), .adc_chan(adc_chan), .alarm_o(alarm_o), .alarm_oe(alarm_oe)
);
